// ### shared/res_defs.svh
`ifndef RES_DEFS_SVH
`define RES_DEFS_SVH

// Core clock rate and documented hiccup timing
`define RES_CLK_MHZ 200
`define RES_HICCUP_US 1700
`define RES_ILIM_COUNT 16
// Soft-start: step timer load (each reference step lasts one cycle more), reference width
`define RES_SS_STEP_CYCLES 64
`define RES_REF_W 7

// Power-on defaults of the configuration bits
`define RES_VSET_A_DEF 7'h48
`define RES_VSET_B_DEF 7'h48
`define RES_SOFT_EN_DEF 1'h1
`define RES_DISCH_DEF 1'h1
`define RES_MODE_DEF 2'h0
`define RES_SLEW_DEF 3'h2

// Input synchroniser lanes
`define RES_SYN_HWEN 0
`define RES_SYN_SEL 1
`define RES_SYN_SUPPLY 2
`define RES_SYN_TICK 3
`define RES_SYN_LIMIT 4
`define RES_SYN_N 5

`endif

// ### shared/res_pkg.sv
`default_nettype none
`include "res_defs.svh"

package res_pkg;

   typedef enum logic [1:0] {
      st_off,
      st_soft,
      st_run,
      st_hiccup
   } res_state_e;

   // Stored configuration, survives hardware disable
   typedef struct packed {
      logic [6:0] vset_a;
      logic [6:0] vset_b;
      logic soft_en_lo;
      logic soft_en_hi;
      logic discharge;
      logic [1:0] mode;
      logic [2:0] slew;
   } res_cfg_s;

   // Drive to the power stage
   typedef struct packed {
      logic run;
      logic sync_rect;
      logic tristate;
      logic discharge;
      logic forced_fixed;
      logic pfm_disable;
   } res_drive_s;

endpackage

`default_nettype wire

// ### src/res_timer.sv
`timescale 1ns/1ps
`default_nettype none

module res_timer
   #(parameter int unsigned CYCLES = 16)
   (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic abort_i,
   output logic done_o
   );

   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_r;

   generate
      if (CYCLES < 1)
      begin : g_chk
         $error("res_timer needs CYCLES of at least one");
      end
   endgenerate

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_r <= '0;
      else if (ce_i)
      begin
         if (abort_i)
            cnt_r <= '0;
         else if (start_i)
            cnt_r <= W'(CYCLES);
         else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         done_o <= 1'b0;
      else if (ce_i)
         done_o <= (cnt_r == W'(1)) && !abort_i && !start_i;
   end

endmodule

`default_nettype wire

// ### src/res_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "res_defs.svh"

module res_regs
   import res_pkg::*;
   (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic supply_ok_i,
   input wire logic wr_i,
   input wire res_cfg_s wdata_i,
   output res_cfg_s cfg_o
   );

   // Only power-on reset clears these; the enable pin never does
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_o.vset_a <= `RES_VSET_A_DEF;
         cfg_o.vset_b <= `RES_VSET_B_DEF;
         cfg_o.soft_en_lo <= `RES_SOFT_EN_DEF;
         cfg_o.soft_en_hi <= `RES_SOFT_EN_DEF;
         cfg_o.discharge <= `RES_DISCH_DEF;
         cfg_o.mode <= `RES_MODE_DEF;
         cfg_o.slew <= `RES_SLEW_DEF;
      end
      else if (ce_i && wr_i && supply_ok_i)
         cfg_o <= wdata_i;
   end

endmodule

`default_nettype wire

// ### src/res_seq.sv
// Overview of operation
// - Enable pin low: regulator fully shut down
// - Register access works while enable pin low
// - Enable pin low never alters registers
// - Registers take defaults only at power-on
// - Discharge load when disabled and discharge set
// - Enable rise with soft bit starts soft-start
// - Soft-start ramps reference, rectification inhibited
// - Sixteen limit cycles: tri-state, wait, restart
// - Both soft enable bits set at power-on
// - Soft bits act only with enable pin high
// - Select pin picks soft bit and mode
// - PFM disable from mode bits and select
// - Select pin picks voltage setting register
`timescale 1ns/1ps
`default_nettype none
`include "res_defs.svh"

module res_seq
   import res_pkg::*;
   #(
   parameter int unsigned SS_STEP_CYCLES = `RES_SS_STEP_CYCLES,
   parameter int unsigned HICCUP_CYCLES = `RES_HICCUP_US * `RES_CLK_MHZ,
   parameter int unsigned ILIM_COUNT = `RES_ILIM_COUNT
   )
   (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic hw_enable_pin_i,
   input wire logic voltage_select_pin_i,
   input wire logic supply_ok_i,
   input wire logic switch_tick_i,
   input wire logic at_limit_i,
   input wire logic cfg_wr_i,
   input wire res_cfg_s cfg_wdata_i,
   output res_cfg_s cfg_o,
   output res_drive_s drive_o,
   output logic [6:0] vset_o,
   output logic [`RES_REF_W-1:0] ref_o,
   output logic internal_on_o,
   output logic hiccup_o
   );

   localparam int LW = $clog2(ILIM_COUNT + 1);

   generate
      if (ILIM_COUNT < 2 || HICCUP_CYCLES < 1 || SS_STEP_CYCLES < 1)
      begin : g_chk
         $error("res_seq parameters out of range");
      end
   endgenerate

   res_state_e state_r;
   res_state_e state_nxt;
   logic [`RES_SYN_N-1:0] meta_r;
   logic [`RES_SYN_N-1:0] sync_r;
   logic tick_d_r;
   logic hw_en_s;
   logic sel_s;
   logic supply_s;
   logic tick_s;
   logic soft_sel;
   logic enable_req;
   logic lim_tick;
   logic clr_tick;
   logic [LW-1:0] ilim_cnt_r;
   logic ilim_trip;
   logic ramp_full;
   logic step_done;
   logic hic_done;
   logic ss_start;
   logic hic_start;
   res_drive_s drive_nxt;

   // Selected soft enable bit for a given select level
   function automatic logic pick_soft(input res_cfg_s c, input logic sel);
      pick_soft = sel ? c.soft_en_hi : c.soft_en_lo;
   endfunction

   // Pins and analogue comparators come from outside the clock domain
   genvar g;
   generate
      for (g = 0; g < `RES_SYN_N; g++)
      begin : g_sync
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end
            else if (clk_en_i)
            begin
               meta_r[g] <= (g == `RES_SYN_HWEN) ? hw_enable_pin_i :
                            (g == `RES_SYN_SEL) ? voltage_select_pin_i :
                            (g == `RES_SYN_SUPPLY) ? supply_ok_i :
                            (g == `RES_SYN_TICK) ? switch_tick_i :
                            at_limit_i;
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign hw_en_s = sync_r[`RES_SYN_HWEN];
   assign sel_s = sync_r[`RES_SYN_SEL];
   assign supply_s = sync_r[`RES_SYN_SUPPLY];
   assign tick_s = sync_r[`RES_SYN_TICK];

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tick_d_r <= 1'b0;
      else if (clk_en_i)
         tick_d_r <= tick_s;
   end

   res_regs u_regs (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(clk_en_i),
      .supply_ok_i(supply_s),
      .wr_i(cfg_wr_i),
      .wdata_i(cfg_wdata_i),
      .cfg_o(cfg_o)
   );

   assign soft_sel = pick_soft(cfg_o, sel_s);
   // Soft bits only count with the pin high
   assign enable_req = hw_en_s && supply_s && soft_sel;

   // One switching cycle ends on each rising tick
   assign lim_tick = tick_s && !tick_d_r && sync_r[`RES_SYN_LIMIT];
   assign clr_tick = tick_s && !tick_d_r && !sync_r[`RES_SYN_LIMIT];
   assign ilim_trip = lim_tick && (ilim_cnt_r == LW'(ILIM_COUNT - 1));

   // Consecutive limit cycles; a clean cycle starts over
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ilim_cnt_r <= '0;
      else if (clk_en_i)
      begin
         if (state_nxt != st_soft && state_nxt != st_run)
            ilim_cnt_r <= '0;
         else if (clr_tick)
            ilim_cnt_r <= '0;
         else if (lim_tick)
            ilim_cnt_r <= ilim_cnt_r + 1'b1;
      end
   end

   assign ramp_full = &ref_o;

   always_comb
   begin
      state_nxt = state_r;
      if (!enable_req)
         state_nxt = st_off;
      else
      begin
         unique case (state_r)
            st_off:
               state_nxt = st_soft;
            st_soft:
               if (ilim_trip)
                  state_nxt = st_hiccup;
               else if (ramp_full)
                  state_nxt = st_run;
            st_run:
               if (ilim_trip)
                  state_nxt = st_hiccup;
            st_hiccup:
               if (hic_done)
                  state_nxt = st_soft;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_r <= st_off;
      else if (clk_en_i)
         state_r <= state_nxt;
   end

   // Timers run on the core clock; lengths are parameters
   assign ss_start = (state_nxt == st_soft) &&
                     ((state_r != st_soft) || (step_done && !ramp_full));
   assign hic_start = (state_nxt == st_hiccup) && (state_r != st_hiccup);

   res_timer #(.CYCLES(SS_STEP_CYCLES)) u_ss_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(clk_en_i),
      .start_i(ss_start),
      .abort_i(state_nxt != st_soft),
      .done_o(step_done)
   );

   res_timer #(.CYCLES(HICCUP_CYCLES)) u_hic_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(clk_en_i),
      .start_i(hic_start),
      .abort_i(state_nxt != st_hiccup),
      .done_o(hic_done)
   );

   // Reference starts from zero so a pre-charged output is not pulled
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ref_o <= '0;
      else if (clk_en_i)
      begin
         if (state_nxt == st_off || state_nxt == st_hiccup)
            ref_o <= '0;
         else if (state_r != st_soft && state_nxt == st_soft)
            ref_o <= '0;
         else if (state_r == st_soft && step_done && !ramp_full)
            ref_o <= ref_o + 1'b1;
      end
   end

   always_comb
   begin
      drive_nxt.run = (state_nxt == st_soft) || (state_nxt == st_run);
      drive_nxt.sync_rect = (state_nxt == st_run);
      drive_nxt.tristate = !drive_nxt.run;
      drive_nxt.discharge = cfg_o.discharge &&
                            (!hw_en_s || !soft_sel);
      drive_nxt.forced_fixed = drive_nxt.run && sel_s;
      drive_nxt.pfm_disable = drive_nxt.forced_fixed ||
         (drive_nxt.run && (sel_s ? cfg_o.mode[1] : cfg_o.mode[0]));
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         drive_o <= '0;
         hiccup_o <= 1'b0;
         internal_on_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         drive_o <= drive_nxt;
         hiccup_o <= (state_nxt == st_hiccup);
         internal_on_o <= hw_en_s;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         vset_o <= `RES_VSET_A_DEF;
      else if (clk_en_i)
         vset_o <= sel_s ? cfg_o.vset_b : cfg_o.vset_a;
   end

   // Checks
   int unsigned hic_age_r;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         hic_age_r <= 0;
      else if (clk_en_i)
         hic_age_r <= (state_nxt == st_hiccup && state_r == st_hiccup) ?
                      hic_age_r + 1 : 0;
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   pin_low_off_a: assert property (
      clk_en_i && !hw_en_s |=> !drive_o.run && drive_o.tristate &&
                               state_r == st_off)
      else $error("running while enable pin low");
   soft_gate_a: assert property (
      clk_en_i && hw_en_s && !soft_sel |=> !drive_o.run)
      else $error("running with selected soft bit clear");
   write_served_a: assert property (
      clk_en_i && cfg_wr_i && supply_s |=> cfg_o == $past(cfg_wdata_i))
      else $error("register write lost");
   regs_kept_a: assert property (
      !(clk_en_i && cfg_wr_i) |=> $stable(cfg_o))
      else $error("registers changed without write");
   // Checked as reset lifts, when the reset values have surely settled
   por_defaults_a: assert property (disable iff (1'b0)
      $rose(rst_n_i) |-> cfg_o.soft_en_lo && cfg_o.soft_en_hi &&
         cfg_o.discharge == `RES_DISCH_DEF &&
         cfg_o.vset_a == `RES_VSET_A_DEF)
      else $error("wrong power-on defaults");
   discharge_a: assert property (
      clk_en_i |=> drive_o.discharge ==
         $past(cfg_o.discharge && (!hw_en_s || !soft_sel)))
      else $error("discharge load wrong");
   ss_entry_a: assert property (
      clk_en_i && state_r == st_off && enable_req |=>
         state_r == st_soft && ref_o == '0 && drive_o.run)
      else $error("soft-start not begun");
   ss_no_rect_a: assert property (
      state_r == st_soft |-> !drive_o.sync_rect)
      else $error("rectification during soft-start");
   hiccup_trip_a: assert property (
      clk_en_i && enable_req && ilim_trip &&
      (state_r == st_soft || state_r == st_run) |=>
         state_r == st_hiccup && drive_o.tristate)
      else $error("limit trip missed");
   hiccup_wait_a: assert property (
      state_r == st_soft && $past(state_r) == st_hiccup |->
         $past(hic_age_r) >= HICCUP_CYCLES)
      else $error("restart too early");
   mode_sel_a: assert property (
      clk_en_i && state_r == st_run && enable_req && !ilim_trip |=>
         drive_o.forced_fixed == $past(sel_s) &&
         (!$past(sel_s) || drive_o.pfm_disable))
      else $error("mode does not follow select");
   vset_pick_a: assert property (
      clk_en_i |=> vset_o ==
         ($past(sel_s) ? $past(cfg_o.vset_b) : $past(cfg_o.vset_a)))
      else $error("wrong voltage setting");
   ss_done_c: cover property (state_r == st_soft ##1 state_r == st_run);
   hiccup_c: cover property (state_r == st_hiccup ##1 state_r == st_soft);
   fixed_run_c: cover property (state_r == st_run && drive_o.forced_fixed);
   pin_drop_c: cover property (state_r == st_run ##1 state_r == st_off);

endmodule

`default_nettype wire

// ### verif/res_host.sv
`timescale 1ns/1ps
`default_nettype none

module res_host
   import res_pkg::*;
   (
   input wire logic clock_i,
   output logic pin_o,
   output logic sel_o,
   output logic supply_o,
   output logic tick_o,
   output logic limit_o,
   output logic wr_o,
   output res_cfg_s wdata_o
   );
   initial
   begin
      pin_o = 1'b0;
      sel_o = 1'b0;
      supply_o = 1'b1;
      tick_o = 1'b0;
      limit_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = '0;
   end

   // Pin levels move just after an edge, never on it
   task automatic pins(input logic p, input logic s, input logic ok);
      @(posedge clock_i);
      #1;
      pin_o = p;
      sel_o = s;
      supply_o = ok;
   endtask

   task automatic write(input res_cfg_s w);
      @(posedge clock_i);
      #1;
      wr_o = 1'b1;
      wdata_o = w;
      @(posedge clock_i);
      #1;
      wr_o = 1'b0;
      // Released data shows the inverse, so stale data cannot pass
      wdata_o = ~w;
   endtask

   task automatic tick(input logic t, input logic lim);
      @(posedge clock_i);
      #1;
      tick_o = t;
      limit_o = lim;
   endtask
endmodule

`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "res_defs.svh"

module tb
   import res_pkg::*;
   ;
   localparam int SS = 2;
   localparam int HC = 20;
   localparam int IL = 16;
   logic clock_i;
   logic rst_n_i;
   logic clk_en_i;
   logic pin, sel, ok, tick, lim, wr;
   res_cfg_s wdata, cfg_o, m_cfg, w;
   res_drive_s drive_o;
   logic [6:0] vset_o;
   logic [6:0] ref_o;
   logic internal_on_o;
   logic hiccup_o;
   logic m_pin, m_sel, m_ok, started;
   logic [16:0] seed;
   logic [6:0] prev;
   int errors, comparisons, k, n;

   res_seq #(.SS_STEP_CYCLES(SS), .HICCUP_CYCLES(HC), .ILIM_COUNT(IL))
      res_seq_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .hw_enable_pin_i(pin), .voltage_select_pin_i(sel), .supply_ok_i(ok),
      .switch_tick_i(tick), .at_limit_i(lim), .cfg_wr_i(wr),
      .cfg_wdata_i(wdata), .cfg_o(cfg_o), .drive_o(drive_o),
      .vset_o(vset_o), .ref_o(ref_o), .internal_on_o(internal_on_o),
      .hiccup_o(hiccup_o));

   res_host res_host_i (.clock_i(clock_i), .pin_o(pin), .sel_o(sel),
      .supply_o(ok), .tick_o(tick), .limit_o(lim), .wr_o(wr),
      .wdata_o(wdata));

   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_vec(input string nm, input logic [21:0] e,
                          input logic [21:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_vec(nm, {21'h0, e}, {21'h0, g});
   endtask

   task automatic waitn(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask

   task automatic set_pins(input logic p, input logic s, input logic o);
      m_pin = p;
      m_sel = s;
      m_ok = o;
      res_host_i.pins(p, s, o);
   endtask

   task automatic wr_cfg(input res_cfg_s v);
      // Writes are dropped while the supply is low
      if (m_ok)
         m_cfg = v;
      res_host_i.write(v);
   endtask

   task automatic rnd_cfg(input logic lo, input logic hi);
      seed = lfsr(seed);
      w = res_cfg_s'({seed, seed[4:0]});
      w.soft_en_lo = lo;
      w.soft_en_hi = hi;
   endtask

   task automatic tick_once(input logic l);
      res_host_i.tick(1'b1, l);
      waitn(3);
      res_host_i.tick(1'b0, l);
      waitn(3);
   endtask

   task automatic steady();
      logic sb, en;
      sb = m_sel ? m_cfg.soft_en_hi : m_cfg.soft_en_lo;
      en = m_pin & m_ok & sb;
      chk_vec("cfg", m_cfg, cfg_o);
      chk_bit("run", en, drive_o.run);
      chk_bit("disch", m_cfg.discharge & ~(m_pin & sb),
              drive_o.discharge);
      chk_bit("ffm", en & m_sel, drive_o.forced_fixed);
      chk_bit("pfm", en & (m_sel | m_cfg.mode[0]),
              drive_o.pfm_disable);
      chk_vec("vset", m_sel ? m_cfg.vset_b : m_cfg.vset_a,
              vset_o);
      chk_bit("inton", m_pin, internal_on_o);
   endtask

   initial
   begin
      errors = 0;
      comparisons = 0;
      seed = 17'd76196;
      m_pin = 1'b0;
      m_sel = 1'b0;
      m_ok = 1'b1;
      rst_n_i = 1'b0;
      clk_en_i = 1'b1;
      waitn(5);
      rst_n_i = 1'b1;
      m_cfg = '{`RES_VSET_A_DEF, `RES_VSET_B_DEF, `RES_SOFT_EN_DEF,
                `RES_SOFT_EN_DEF, `RES_DISCH_DEF, `RES_MODE_DEF,
                `RES_SLEW_DEF};
      chk_bit("en_lo", 1'b1, cfg_o.soft_en_lo);
      chk_bit("en_hi", 1'b1, cfg_o.soft_en_hi);
      chk_vec("cfg", m_cfg, cfg_o);
      waitn(6);
      steady();
      $display("test reset done");

      // Every pin and soft bit combination, written with pin low too
      for (int i = 0; i < 16; i++)
      begin
         rnd_cfg(i[0], i[1]);
         wr_cfg(w);
         set_pins(i[3], i[2], 1'b1);
         waitn(6);
         steady();
      end
      $display("test table done");

      set_pins(1'b1, 1'b0, 1'b0);
      waitn(4);
      rnd_cfg(1'b1, 1'b1);
      wr_cfg(w);
      waitn(2);
      chk_vec("cfg", m_cfg, cfg_o);
      chk_bit("run", 1'b0, drive_o.run);
      $display("test supply done");

      rnd_cfg(1'b1, 1'b0);
      set_pins(1'b0, 1'b0, 1'b1);
      // Supply must pass its synchroniser before a write is taken
      waitn(2);
      wr_cfg(w);
      waitn(6);
      set_pins(1'b1, 1'b0, 1'b1);
      started = 1'b0;
      prev = 7'h0;
      for (k = 0; k < 600; k++)
      begin
         waitn(1);
         if (drive_o.run === 1'b1 && !started)
         begin
            started = 1'b1;
            n = k;
            chk_vec("ref0", 7'h0, ref_o);
            chk_bit("srect", 1'b0, drive_o.sync_rect);
         end
         if (started && ref_o < prev)
            chk_vec("ramp", prev, ref_o);
         prev = ref_o;
         if (drive_o.sync_rect === 1'b1)
            break;
      end
      if (k == 600)
      begin
         errors++;
         final_report();
      end
      chk_vec("reftop", 7'h7f, ref_o);
      chk_vec("rampl", 22'(127 * (SS + 1) + 1), 22'(k - n));
      $display("test ramp done");

      for (int j = 0; j < IL - 1; j++)
         tick_once(1'b1);
      tick_once(1'b0);
      chk_bit("hic", 1'b0, hiccup_o);
      for (int j = 0; j < IL - 1; j++)
         tick_once(1'b1);
      res_host_i.tick(1'b1, 1'b1);
      n = 0;
      for (k = 0; k < 60; k++)
      begin
         waitn(1);
         if (hiccup_o === 1'b1)
         begin
            if (n == 0)
            begin
               chk_bit("tri", 1'b1, drive_o.tristate);
               chk_bit("hrun", 1'b0, drive_o.run);
            end
            n++;
         end
      end
      res_host_i.tick(1'b0, 1'b0);
      chk_vec("hlen", 22'(HC + 1), 22'(n));
      chk_bit("rerun", 1'b1, drive_o.run);
      chk_bit("resoft", 1'b0, drive_o.sync_rect);
      $display("test hiccup done");

      // Frozen core must ignore the pin drop until enabled again
      clk_en_i = 1'b0;
      set_pins(1'b0, 1'b0, 1'b1);
      waitn(6);
      chk_bit("frun", 1'b1, drive_o.run);
      chk_bit("fon", 1'b1, internal_on_o);
      clk_en_i = 1'b1;
      waitn(6);
      steady();
      $display("test freeze done");
      final_report();
   end
endmodule

`default_nettype wire
